// ### shared/upfp_pkg.sv
// package: shared constants and types for the parallel fifo port
package upfp_pkg;
    // clock and timing
    localparam int CORE_CLK_MHZ = 125;
    localparam int FIFO_CLK_MHZ = 60;
    // divider for the output clock, rounded to the nearest whole half period
    localparam int FIFO_CLK_HALF = (CORE_CLK_MHZ + FIFO_CLK_MHZ) / (2 * FIFO_CLK_MHZ);
    localparam int FLAG_GAP_NS = 49;
    localparam int FLAG_GAP_CYC = (FLAG_GAP_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int STROBE_PULSE_NS = 30;
    localparam int STROBE_PULSE_CYC = (STROBE_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;

    typedef enum logic {
        UPFP_MODE_ASYNC,
        UPFP_MODE_SYNC
    } upfp_mode_e;
endpackage

// ### shared/upfp_if.sv
// interface: pins between the fifo port device and the external system
`timescale 1ns/1ps
interface upfp_if;
    logic fifo_clock_out;
    logic rx_data_avail_n;
    logic tx_space_avail_n;
    logic out_turn_n;
    logic rd_strobe_n;
    logic wr_strobe_n;
    logic [7:0] dev_data_o;
    logic dev_data_oe;
    logic [7:0] ext_data_o;
    logic ext_data_oe;

    modport dev (
        output fifo_clock_out,
        output rx_data_avail_n,
        output tx_space_avail_n,
        input out_turn_n,
        input rd_strobe_n,
        input wr_strobe_n,
        output dev_data_o,
        output dev_data_oe,
        input ext_data_o,
        input ext_data_oe
    );

    modport ext (
        input fifo_clock_out,
        input rx_data_avail_n,
        input tx_space_avail_n,
        output out_turn_n,
        output rd_strobe_n,
        output wr_strobe_n,
        input dev_data_o,
        input dev_data_oe,
        output ext_data_o,
        output ext_data_oe
    );
endinterface

// ### verilog/upfp_device.sv
// device end of the parallel fifo port
`timescale 1ns/1ps
module upfp_device (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link
    upfp_if.dev link,
    // mode selection
    input wire logic sync_mode,
    // bytes toward the external system
    input wire logic [7:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    // bytes from the external system
    output logic [7:0] snk_data,
    output logic snk_valid,
    input wire logic snk_ready
);
    localparam int HALF = upfp_pkg::FIFO_CLK_HALF;
    localparam int GAP = upfp_pkg::FLAG_GAP_CYC;

    // ------------------------------------------------------------
    // output clock
    // ------------------------------------------------------------
    logic [upfp_pkg::CNT_W-1:0] div_cnt;
    logic clk_o;
    logic clk_seen;
    logic clk_rise;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            clk_o <= 1'b0;
        end else if (!sync_mode) begin
            div_cnt <= '0;
            clk_o <= 1'b0;
        end else if (div_cnt == upfp_pkg::CNT_W'(HALF - 1)) begin
            div_cnt <= '0;
            clk_o <= ~clk_o;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_seen <= 1'b0;
        end else begin
            clk_seen <= clk_o;
        end
    end
    // link edge is the first core edge that sees the pin high, the same
    // edge the far end finds from its registered copy, so both sample alike
    assign clk_rise = sync_mode && clk_o && !clk_seen;
    assign link.fifo_clock_out = clk_o;

    // ------------------------------------------------------------
    // strobe edges (async mode)
    // ------------------------------------------------------------
    logic rd_prev;
    logic wr_prev;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end else begin
            rd_prev <= link.rd_strobe_n;
            wr_prev <= link.wr_strobe_n;
        end
    end
    wire rd_fall = rd_prev && !link.rd_strobe_n;
    wire rd_rise = !rd_prev && link.rd_strobe_n;
    wire wr_fall = wr_prev && !link.wr_strobe_n;
    wire wr_rise = !wr_prev && link.wr_strobe_n;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    logic rd_full;
    logic rxf_n;
    logic [upfp_pkg::CNT_W-1:0] rd_gap;
    logic rd_busy;
    logic rd_take;
    // sync: byte consumed on a clock edge with turn and strobe low;
    // a write needs turn high, so only one direction moves per edge
    assign rd_take = sync_mode ? (clk_rise && rd_full && !rxf_n && !link.out_turn_n
                                  && !link.rd_strobe_n)
                               : (rd_fall && rd_full && !rxf_n);
    // async: the byte stays on the bus until the strobe cycle has ended
    assign src_ready = sync_mode ? (!rd_full || rd_take) : (!rd_full && !rd_busy);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_byte <= '0;
            rd_full <= 1'b0;
        end else if (src_valid && src_ready) begin
            rd_byte <= src_data;
            rd_full <= 1'b1;
        end else if (rd_take) begin
            rd_full <= 1'b0;
        end
    end
    // async: hold flag off from strobe until gap after its release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_busy <= 1'b0;
            rd_gap <= '0;
        end else if (rd_take && !sync_mode) begin
            rd_busy <= 1'b1;
        end else if (rd_busy && rd_rise) begin
            rd_busy <= 1'b0;
            rd_gap <= upfp_pkg::CNT_W'(GAP);
        end else if (rd_gap != '0) begin
            rd_gap <= rd_gap - 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxf_n <= 1'b1;
        end else if (sync_mode) begin
            // flag changes only at link clock edges
            if (clk_rise) begin
                rxf_n <= !(rd_full && !rd_take) && !(src_valid && src_ready);
            end
        end else begin
            rxf_n <= !rd_full || rd_take || rd_busy || rd_gap != '0;
        end
    end
    assign link.rx_data_avail_n = rxf_n;

    // bus drive
    logic data_oe;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= sync_mode ? !link.out_turn_n : !link.rd_strobe_n;
        end
    end
    assign link.dev_data_oe = data_oe;
    assign link.dev_data_o = rd_byte;

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    logic txe_n;
    logic [upfp_pkg::CNT_W-1:0] wr_gap;
    logic wr_busy;
    logic wr_take;
    assign wr_take = sync_mode ? (clk_rise && !txe_n && !link.wr_strobe_n && link.out_turn_n)
                               : (wr_fall && !txe_n);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snk_data <= '0;
            snk_valid <= 1'b0;
        end else if (wr_take) begin
            snk_data <= link.ext_data_o;
            snk_valid <= 1'b1;
        end else if (snk_ready) begin
            snk_valid <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_busy <= 1'b0;
            wr_gap <= '0;
        end else if (wr_take && !sync_mode) begin
            wr_busy <= 1'b1;
        end else if (wr_busy && wr_rise) begin
            wr_busy <= 1'b0;
            wr_gap <= upfp_pkg::CNT_W'(GAP);
        end else if (wr_gap != '0) begin
            wr_gap <= wr_gap - 1'b1;
        end
    end
    // space when holding register empties; sync flag updates on link edges
    wire wr_room = !snk_valid || snk_ready;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txe_n <= 1'b1;
        end else if (sync_mode) begin
            if (clk_rise) begin
                txe_n <= !(wr_room && !wr_take) || !link.out_turn_n;
            end
        end else begin
            txe_n <= !wr_room || wr_take || wr_busy || wr_gap != '0;
        end
    end
    assign link.tx_space_avail_n = txe_n;
endmodule

// ### verilog/upfp_host.sv
// external system end of the parallel fifo port
`timescale 1ns/1ps
module upfp_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link
    upfp_if.ext link,
    // mode in use, set only after both channels were async
    input wire logic sync_mode,
    // bytes read from the device
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_enable,
    // bytes written to the device
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready
);
    localparam int PW = upfp_pkg::STROBE_PULSE_CYC;

    typedef enum logic [2:0] {UPFP_IDLE, UPFP_TURN, UPFP_READ, UPFP_WRITE, UPFP_REL} upfp_state_e;
    upfp_state_e state;
    logic clk_prev;
    logic [upfp_pkg::CNT_W-1:0] pulse;
    logic oe_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] dout;
    logic dout_en;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= link.fifo_clock_out;
        end
    end
    wire clk_rise = !clk_prev && link.fifo_clock_out;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= UPFP_IDLE;
            oe_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            dout <= '0;
            dout_en <= 1'b0;
            pulse <= '0;
            rd_data <= '0;
            rd_valid <= 1'b0;
            wr_ready <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            wr_ready <= 1'b0;
            if (pulse != '0) begin
                pulse <= pulse - 1'b1;
            end
            case (state)
                UPFP_IDLE: begin
                    if (rd_enable && !link.rx_data_avail_n) begin
                        if (sync_mode) begin
                            oe_n <= 1'b0;
                            state <= UPFP_TURN;
                        end else begin
                            rd_n <= 1'b0;
                            pulse <= upfp_pkg::CNT_W'(PW);
                            state <= UPFP_READ;
                        end
                    end else if (wr_valid && !link.tx_space_avail_n) begin
                        dout <= wr_data;
                        dout_en <= 1'b1;
                        wr_n <= 1'b0;
                        pulse <= upfp_pkg::CNT_W'(PW);
                        state <= UPFP_WRITE;
                    end
                end
                UPFP_TURN: begin
                    if (clk_rise) begin
                        rd_n <= 1'b0;
                        state <= UPFP_READ;
                    end
                end
                UPFP_READ: begin
                    if (sync_mode) begin
                        if (clk_rise) begin
                            if (!link.rx_data_avail_n && !rd_n) begin
                                rd_data <= link.dev_data_o;
                                rd_valid <= 1'b1;
                            end
                            if (link.rx_data_avail_n || !rd_enable) begin
                                rd_n <= 1'b1;
                                oe_n <= 1'b1;
                                state <= UPFP_IDLE;
                            end
                        end
                    end else if (pulse == '0) begin
                        rd_data <= link.dev_data_o;
                        rd_valid <= 1'b1;
                        rd_n <= 1'b1;
                        state <= UPFP_REL;
                    end
                end
                UPFP_WRITE: begin
                    if (sync_mode) begin
                        if (clk_rise) begin
                            if (!link.tx_space_avail_n) begin
                                wr_ready <= 1'b1;
                                wr_n <= 1'b1;
                                dout_en <= 1'b0;
                                state <= UPFP_IDLE;
                            end
                        end
                    end else if (pulse == '0) begin
                        wr_ready <= 1'b1;
                        wr_n <= 1'b1;
                        state <= UPFP_REL;
                    end
                end
                UPFP_REL: begin
                    dout_en <= 1'b0;
                    state <= UPFP_IDLE; // flag is already off, wait in idle
                end
                default: begin
                    state <= UPFP_IDLE;
                end
            endcase
        end
    end
    assign link.out_turn_n = oe_n;
    assign link.rd_strobe_n = rd_n;
    assign link.wr_strobe_n = wr_n;
    assign link.ext_data_o = dout;
    assign link.ext_data_oe = dout_en;
endmodule

// ### bench/upfp_port_props.sv
// checker: link timing properties of the parallel fifo port
`timescale 1ns/1ps
module upfp_port_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // mode
    input wire logic sync_mode,
    // link
    input wire logic fifo_clock_out,
    input wire logic rx_data_avail_n,
    input wire logic tx_space_avail_n,
    input wire logic out_turn_n,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic dev_data_oe,
    input wire logic ext_data_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----
    // sequences
    // ----
    // three cycles of margin so a mode change may settle first
    sequence s_async_held;
        !sync_mode [*3];
    endsequence
    sequence s_sync_held;
        sync_mode [*3];
    endsequence
    sequence s_rx_gap;
        rx_data_avail_n [*7];
    endsequence
    sequence s_tx_gap;
        tx_space_avail_n [*7];
    endsequence
    // ----
    // properties
    // ----
    property p_no_clock_async;
        s_async_held |-> !fifo_clock_out;
    endproperty
    a_no_clock_async: assert property (p_no_clock_async) else $error("clock out runs in async mode");
    property p_clock_runs;
        s_sync_held |-> fifo_clock_out != $past(fifo_clock_out);
    endproperty
    a_clock_runs: assert property (p_clock_runs) else $error("clock out stalled in sync mode");
    property p_rx_gap;
        !sync_mode && $rose(rd_strobe_n) |-> s_rx_gap;
    endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("read flag came back too early");
    property p_tx_gap;
        !sync_mode && $rose(wr_strobe_n) |-> s_tx_gap;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("write flag came back too early");
    property p_rd_after_flag;
        !sync_mode && $fell(rd_strobe_n) |-> $past(rx_data_avail_n) == 1'b0;
    endproperty
    a_rd_after_flag: assert property (p_rd_after_flag) else $error("read strobe before data flag");
    property p_wr_after_flag;
        !sync_mode && $fell(wr_strobe_n) |-> $past(tx_space_avail_n) == 1'b0;
    endproperty
    a_wr_after_flag: assert property (p_wr_after_flag) else $error("write strobe before space flag");
    property p_turn_first;
        sync_mode && $fell(rd_strobe_n) |-> !out_turn_n && $past(out_turn_n) == 1'b0;
    endproperty
    a_turn_first: assert property (p_turn_first) else $error("read strobe before bus turn");
    property p_one_dir;
        sync_mode |-> rd_strobe_n || wr_strobe_n;
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("both strobes low in sync mode");
    property p_oe_sync;
        sync_mode && $past(sync_mode) |-> dev_data_oe == !$past(out_turn_n);
    endproperty
    a_oe_sync: assert property (p_oe_sync) else $error("bus drive not tied to turn enable");
    property p_oe_async;
        !sync_mode && !$past(sync_mode) |-> dev_data_oe == !$past(rd_strobe_n);
    endproperty
    a_oe_async: assert property (p_oe_async) else $error("bus drive not tied to read strobe");
    property p_no_contention;
        !(dev_data_oe && ext_data_oe);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("both ends drive the bus");
    property p_wr_when_space;
        sync_mode && $fell(wr_strobe_n) |-> $past(tx_space_avail_n) == 1'b0;
    endproperty
    a_wr_when_space: assert property (p_wr_when_space) else $error("write strobe without space flag");
endmodule

// ### bench/tb_usb_parallel_fifo_port.sv
// testbench: both ends of the parallel fifo port joined on one link
`timescale 1ns/1ps
module tb_usb_parallel_fifo_port;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sync_mode = 1'b0;
    logic [7:0] src_data = 8'h00;
    logic src_valid = 1'b0;
    logic src_ready;
    logic [7:0] snk_data;
    logic snk_valid;
    logic snk_ready = 1'b1;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_enable = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic wr_valid = 1'b0;
    logic wr_ready;
    logic bad_snk_valid;
    logic [7:0] got_q[$];
    int num_errors = 0;
    int cmp_count = 0;

    always #4 core_clk = ~core_clk;

    upfp_if upfp_if_i ();
    upfp_if bad_if_i ();
    upfp_device upfp_device_i (.core_clk(core_clk), .rst_n(rst_n), .link(upfp_if_i.dev), .sync_mode(sync_mode),
        .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .snk_data(snk_data),
        .snk_valid(snk_valid), .snk_ready(snk_ready));
    upfp_host upfp_host_i (.core_clk(core_clk), .rst_n(rst_n), .link(upfp_if_i.ext), .sync_mode(sync_mode),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_enable(rd_enable), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready));
    // second device faces a hand-driven far side that breaks the write rules
    upfp_device upfp_device_bad_i (.core_clk(core_clk), .rst_n(rst_n), .link(bad_if_i.dev), .sync_mode(1'b1),
        .src_data(8'h00), .src_valid(1'b0), .src_ready(), .snk_data(), .snk_valid(bad_snk_valid),
        .snk_ready(1'b1));
    upfp_port_props upfp_port_props_i (.core_clk(core_clk), .rst_n(rst_n), .sync_mode(sync_mode),
        .fifo_clock_out(upfp_if_i.fifo_clock_out), .rx_data_avail_n(upfp_if_i.rx_data_avail_n),
        .tx_space_avail_n(upfp_if_i.tx_space_avail_n), .out_turn_n(upfp_if_i.out_turn_n),
        .rd_strobe_n(upfp_if_i.rd_strobe_n), .wr_strobe_n(upfp_if_i.wr_strobe_n),
        .dev_data_oe(upfp_if_i.dev_data_oe), .ext_data_oe(upfp_if_i.ext_data_oe));

    always @(posedge core_clk) begin
        if (rd_valid === 1'b1) got_q.push_back(rd_data);
        if (snk_valid === 1'b1 && snk_ready === 1'b1) got_q.push_back(snk_data);
    end

    // ----
    // helpers
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // byte handed to the host end, held until it reports it consumed
    task automatic send_host(input logic [7:0] b);
        int n;
        n = 0;
        wr_data <= b;
        wr_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (wr_ready !== 1'b1 && n < 500);
        if (n >= 500) chk(8'h00, 8'hff);
    endtask

    task automatic send_dev(input logic [7:0] b);
        int n;
        n = 0;
        src_data <= b;
        src_valid <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (src_ready !== 1'b1 && n < 500);
        if (n >= 500) chk(8'h00, 8'hfe);
    endtask

    task automatic check_q(input logic [7:0] base);
        int n;
        n = 0;
        while (got_q.size() < 4 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        chk(8'(got_q.size()), 8'h04);
        for (int i = 0; i < got_q.size() && i < 4; i++) chk(got_q[i], base + 8'(i));
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_idle();
        chk({4'h0, upfp_if_i.rd_strobe_n, upfp_if_i.wr_strobe_n, upfp_if_i.out_turn_n,
            upfp_if_i.rx_data_avail_n}, 8'h0f);
        chk({7'h00, upfp_if_i.dev_data_oe}, 8'h00);
    endtask

    // back-to-back writes, bytes must arrive whole and in order
    task automatic t_write(input logic [7:0] base);
        got_q.delete();
        for (int i = 0; i < 4; i++) send_host(base + 8'(i));
        wr_valid <= 1'b0;
        check_q(base);
    endtask

    task automatic t_read(input logic [7:0] base);
        got_q.delete();
        rd_enable <= 1'b1;
        for (int i = 0; i < 4; i++) send_dev(base + 8'(i));
        src_valid <= 1'b0;
        check_q(base);
        repeat (12) @(posedge core_clk);
        chk({7'h00, upfp_if_i.rx_data_avail_n}, 8'h01);
        rd_enable <= 1'b0;
    endtask

    // write strobe with the bus turned toward the far side must be ignored
    task automatic t_refuse();
        bad_if_i.out_turn_n <= 1'b0;
        bad_if_i.wr_strobe_n <= 1'b0;
        bad_if_i.ext_data_o <= 8'h5a;
        repeat (10) begin
            @(posedge core_clk);
            chk({7'h00, bad_snk_valid}, 8'h00);
        end
        bad_if_i.out_turn_n <= 1'b1;
        bad_if_i.wr_strobe_n <= 1'b1;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        bad_if_i.out_turn_n <= 1'b1;
        bad_if_i.rd_strobe_n <= 1'b1;
        bad_if_i.wr_strobe_n <= 1'b1;
        bad_if_i.ext_data_o <= 8'h00;
        bad_if_i.ext_data_oe <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_idle();
        t_write(8'h10);
        t_read(8'h80);
        sync_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_read(8'hc0);
        t_write(8'h30);
        t_refuse();
        stop_test();
    end
endmodule
